/* File: rtl/flash_defines.svh */
`ifndef FLASH_DEFINES_SVH
`define FLASH_DEFINES_SVH
// instruction codes
`define OP_READ 8'h03
`define OP_FAST_READ 8'h0b
`define OP_DUAL_OUT 8'h3b
`define OP_DUAL_IO 8'hbb
`define OP_QUAD_OUT 8'h6b
`define OP_QUAD_IO 8'heb
`define OP_DTR_READ 8'h0d
`define OP_QUAD_DTR 8'hed
`define OP_PROG 8'h02
`define OP_QUAD_PROG 8'h32
`define OP_SECT_ERASE 8'h20
`define OP_SECT_ERASE_ALT 8'hd7
`define OP_BLK32_ERASE 8'h52
`define OP_BLK_ERASE 8'hd8
`define OP_CHIP_ERASE 8'hc7
`define OP_CHIP_ERASE_ALT 8'h60
`define OP_WR_EN 8'h06
`define OP_WR_DIS 8'h04
`define OP_STATUS 8'h05
`define OP_QUAD_ENTER 8'h35
`define OP_QUAD_EXIT 8'hf5
`define OP_ADDR4_ENTER 8'hb7
`define OP_ADDR4_EXIT 8'h29
`define OP_RST_ARM 8'h66
`define OP_RST_GO 8'h99
`define OP_READ_PARAM 8'hc0
// dummy clocks per read flavour
`define DUMMY_FAST 5'h08
`define DUMMY_DUAL_IO 5'h04
`define DUMMY_QUAD_IO 5'h06
`define DUMMY_DTR 5'h08
// erase unit sizes as address bit counts
`define SHIFT_SECTOR 6'h0c
`define SHIFT_BLK32 6'h0f
`define SHIFT_BLK64 6'h10
`define SHIFT_BLK256 6'h12
// field positions
`define WRAP_EN_BIT 4
`define WRAP_LEN_LSB 5
`define STAT_WEL_BIT 1
// reset values and counts
`define ERASED_BYTE 8'hff
`define LINK_RST_HOLD 4'h8
`define ADDR3_BITS 6'h18
`define ADDR4_BITS 6'h20
`define BYTE_BITS 6'h08
`endif

/* File: rtl/fl_pkg.sv */
package fl_pkg;
  typedef struct packed {
    logic data_line_3;
    logic data_line_2;
    logic data_line_1;
    logic data_line_0;
  } lines_t;
  typedef struct packed {
    logic four_line_command_mode;
    logic addr4_mode;
    logic wrap_enable;
    logic write_enabled;
  } mode_status_t;
  typedef enum logic [2:0] {
    PH_INST, PH_ADDR, PH_DUMMY, PH_RDATA, PH_WDATA, PH_PARAM, PH_IGNORE
  } phase_t;
  typedef enum logic [2:0] {
    K_NONE, K_READ, K_PROG, K_ERASE, K_STATUS, K_PARAM
  } kind_t;
  typedef struct packed {
    kind_t kind;
    logic [2:0] addr_w;
    logic [2:0] data_w;
    logic dtr;
    logic [4:0] dummy;
    logic [5:0] erase_shift;
    logic erase_all;
  } cmd_t;
endpackage

/* File: rtl/serial_flash_host_interface.sv */
`timescale 1ns/1ps
`include "flash_defines.svh"
module serial_flash_host_interface #(
  parameter int MEM_AW = 10,
  parameter int PAGE_AW = 8,
  parameter bit BIG_BLOCK = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire fl_pkg::lines_t lines_in,
  output fl_pkg::lines_t lines_out,
  output fl_pkg::lines_t lines_oe_n,
  output fl_pkg::mode_status_t mode_status
);
  localparam int DEPTH = 1 << MEM_AW;
  typedef logic [DEPTH-1:0][7:0] mem_t;
  typedef struct packed {
    fl_pkg::phase_t phase;
    fl_pkg::cmd_t cmd;
    logic [31:0] sh;
    logic [5:0] bits;
    logic [31:0] addr;
    logic [4:0] dummy;
    logic [7:0] rd_byte;
    logic [3:0] rd_bits;
    logic fall_pend;
    logic [3:0] out_fall;
    logic [3:0] rise_x;
    logic [3:0] drive;
    logic four_line;
    logic addr4;
    logic wrap_en;
    logic [1:0] wrap_len;
    logic wel;
    logic rst_armed;
    mem_t mem;
  } link_st_t;
  typedef struct packed {
    logic [3:0] hold;
    logic link_rst;
    fl_pkg::mode_status_t sync1;
    fl_pkg::mode_status_t sync2;
  } sys_st_t;

  function automatic link_st_t link_init();
    link_st_t s;
    s = '0;
    s.phase = fl_pkg::PH_IGNORE;
    s.mem = {DEPTH{`ERASED_BYTE}};
    return s;
  endfunction
  localparam link_st_t LINK_INIT = link_init();

  // pick the low w lanes of a pin sample
  function automatic logic [3:0] lane_in(logic [2:0] w, logic [3:0] v);
    case (w)
      3'h4: lane_in = v;
      3'h2: lane_in = {2'h0, v[1:0]};
      default: lane_in = {3'h0, v[0]};
    endcase
  endfunction

  // place a w-bit output unit on its lanes
  function automatic logic [3:0] lane_out(logic [2:0] w, logic [3:0] u);
    case (w)
      3'h4: lane_out = u;
      3'h2: lane_out = {2'h0, u[1:0]};
      default: lane_out = {2'h0, u[0], 1'b0};
    endcase
  endfunction

  function automatic logic [31:0] wrap_inc(logic [31:0] a, int n, logic en);
    logic [31:0] m;
    logic [31:0] s;
    m = (32'h1 << n) - 32'h1;
    s = a + 32'h1;
    wrap_inc = en ? ((a & ~m) | (s & m)) : s;
  endfunction

  // lane widths, dummies and erase size by instruction
  function automatic fl_pkg::cmd_t decode(logic [7:0] op, logic quad);
    fl_pkg::cmd_t c;
    c = '0;
    case (op)
      `OP_READ, `OP_FAST_READ, `OP_DUAL_OUT, `OP_DUAL_IO, `OP_QUAD_OUT, `OP_QUAD_IO,
      `OP_DTR_READ, `OP_QUAD_DTR: c.kind = fl_pkg::K_READ;
      `OP_PROG, `OP_QUAD_PROG: c.kind = fl_pkg::K_PROG;
      `OP_SECT_ERASE, `OP_SECT_ERASE_ALT, `OP_BLK32_ERASE,
      `OP_BLK_ERASE: c.kind = fl_pkg::K_ERASE;
      `OP_STATUS: c.kind = fl_pkg::K_STATUS;
      `OP_READ_PARAM: c.kind = fl_pkg::K_PARAM;
      default: c.kind = fl_pkg::K_NONE;
    endcase
    case (op)
      `OP_DUAL_IO: c.addr_w = 3'h2;
      `OP_QUAD_IO, `OP_QUAD_DTR: c.addr_w = 3'h4;
      default: c.addr_w = 3'h1;
    endcase
    case (op)
      `OP_DUAL_OUT, `OP_DUAL_IO: c.data_w = 3'h2;
      `OP_QUAD_OUT, `OP_QUAD_IO, `OP_QUAD_DTR, `OP_QUAD_PROG: c.data_w = 3'h4;
      default: c.data_w = 3'h1;
    endcase
    case (op)
      `OP_FAST_READ, `OP_DUAL_OUT, `OP_QUAD_OUT: c.dummy = `DUMMY_FAST;
      `OP_DUAL_IO: c.dummy = `DUMMY_DUAL_IO;
      `OP_QUAD_IO: c.dummy = `DUMMY_QUAD_IO;
      `OP_DTR_READ, `OP_QUAD_DTR: c.dummy = `DUMMY_DTR;
      default: c.dummy = 5'h00;
    endcase
    case (op)
      `OP_BLK32_ERASE: c.erase_shift = `SHIFT_BLK32;
      `OP_BLK_ERASE: c.erase_shift = BIG_BLOCK ? `SHIFT_BLK256 : `SHIFT_BLK64;
      default: c.erase_shift = `SHIFT_SECTOR;
    endcase
    c.dtr = (op == `OP_DTR_READ) || (op == `OP_QUAD_DTR);
    c.erase_all = (op == `OP_CHIP_ERASE) || (op == `OP_CHIP_ERASE_ALT);
    // every phase runs four lanes wide once in four-line mode
    if (quad)
    begin
      c.addr_w = 3'h4;
      c.data_w = 3'h4;
      if (c.kind == fl_pkg::K_READ)
        c.dummy = `DUMMY_QUAD_IO;
    end
    return c;
  endfunction

  function automatic logic [7:0] fetch(link_st_t s);
    if (s.cmd.kind == fl_pkg::K_STATUS)
      fetch = 8'(s.wel) << `STAT_WEL_BIT;
    else
      fetch = s.mem[s.addr[MEM_AW-1:0]];
  endfunction

  function automatic link_st_t begin_read(link_st_t s);
    s.phase = fl_pkg::PH_RDATA;
    s.rd_byte = fetch(s);
    s.rd_bits = 4'h8;
    s.drive = lane_out(s.cmd.data_w, 4'hf);
    return s;
  endfunction

  // erase every byte in the unit that holds the address
  function automatic link_st_t erase(link_st_t s);
    logic [31:0] a;
    a = s.addr & 32'(DEPTH - 1);
    for (int i = 0; i < DEPTH; i++)
    begin
      if (s.cmd.erase_all || (((32'(i) ^ a) >> s.cmd.erase_shift) == 32'h0))
        s.mem[i] = `ERASED_BYTE;
    end
    s.wel = 1'b0;
    return s;
  endfunction

  // close the phase whose last unit has just arrived
  function automatic link_st_t finish(link_st_t s);
    logic [7:0] op;
    logic armed;
    op = s.sh[7:0];
    armed = s.rst_armed;
    case (s.phase)
      fl_pkg::PH_INST:
      begin
        s.cmd = decode(op, s.four_line);
        s.rst_armed = (op == `OP_RST_ARM);
        s.phase = fl_pkg::PH_IGNORE;
        case (op)
          `OP_WR_EN: s.wel = 1'b1;
          `OP_WR_DIS: s.wel = 1'b0;
          `OP_QUAD_ENTER: s.four_line = 1'b1;
          `OP_QUAD_EXIT: s.four_line = 1'b0;
          `OP_ADDR4_ENTER: s.addr4 = 1'b1;
          `OP_ADDR4_EXIT: s.addr4 = 1'b0;
          default: ;
        endcase
        // software reset only after the arming instruction
        if (op == `OP_RST_GO && armed)
        begin
          s.four_line = 1'b0;
          s.addr4 = 1'b0;
          s.wrap_en = 1'b0;
          s.wrap_len = 2'h0;
          s.wel = 1'b0;
        end
        if (s.cmd.erase_all && s.wel)
          s = erase(s);
        case (s.cmd.kind)
          fl_pkg::K_READ, fl_pkg::K_PROG, fl_pkg::K_ERASE:
          begin
            s.phase = fl_pkg::PH_ADDR;
            s.bits = s.addr4 ? `ADDR4_BITS : `ADDR3_BITS;
          end
          fl_pkg::K_STATUS: s = begin_read(s);
          fl_pkg::K_PARAM:
          begin
            s.phase = fl_pkg::PH_PARAM;
            s.bits = `BYTE_BITS;
          end
          default: ;
        endcase
      end
      fl_pkg::PH_ADDR:
      begin
        s.addr = s.addr4 ? s.sh : {8'h00, s.sh[23:0]};
        s.phase = fl_pkg::PH_IGNORE;
        case (s.cmd.kind)
          fl_pkg::K_READ:
          begin
            s.dummy = s.cmd.dummy;
            if (s.cmd.dummy == 5'h00)
              s = begin_read(s);
            else
              s.phase = fl_pkg::PH_DUMMY;
          end
          fl_pkg::K_PROG:
          begin
            // a program without write enable is ignored
            if (s.wel)
              s.phase = fl_pkg::PH_WDATA;
            s.bits = `BYTE_BITS;
            s.wel = 1'b0;
          end
          fl_pkg::K_ERASE:
          begin
            if (s.wel)
              s = erase(s);
          end
          default: ;
        endcase
      end
      fl_pkg::PH_WDATA:
      begin
        // programming only clears bits, as in the real array
        s.mem[s.addr[MEM_AW-1:0]] = s.mem[s.addr[MEM_AW-1:0]] & op;
        s.addr = wrap_inc(s.addr, PAGE_AW, 1'b1);
        s.bits = `BYTE_BITS;
      end
      fl_pkg::PH_PARAM:
      begin
        s.wrap_en = op[`WRAP_EN_BIT];
        s.wrap_len = op[`WRAP_LEN_LSB +: 2];
        s.phase = fl_pkg::PH_IGNORE;
      end
      default: ;
    endcase
    return s;
  endfunction

  link_st_t link_ff;
  link_st_t nxt_link;
  sys_st_t sys_ff;
  sys_st_t nxt_sys;
  logic live_ff;
  logic [3:0] fall_in_ff;
  logic [3:0] fall_x_ff;
  logic frame_clr;
  logic [3:0] pin_in;

  assign pin_in = lines_in;
  // chip enable high ends the frame at once, clock or not
  assign frame_clr = cs_n | sys_ff.link_rst;

  // link engine: up to two input units and two output units per rising edge
  always_comb
  begin
    logic [3:0] smp;
    logic [2:0] w;
    logic [3:0] unit;
    logic was_rd;
    nxt_link = link_ff;
    smp = 4'h0;
    w = 3'h1;
    unit = 4'h0;
    was_rd = live_ff && (link_ff.phase == fl_pkg::PH_RDATA);
    // first rising edge of a frame starts a fresh instruction
    if (!live_ff)
    begin
      nxt_link.phase = fl_pkg::PH_INST;
      nxt_link.bits = `BYTE_BITS;
      nxt_link.sh = 32'h0;
      nxt_link.fall_pend = 1'b0;
      nxt_link.drive = 4'h0;
    end
    // unit 0 is the falling-edge sample of a double-edge address
    for (int k = 0; k < 2; k++)
    begin
      smp = (k == 0) ? fall_in_ff : pin_in;
      if (k == 1 || nxt_link.fall_pend)
      begin
        case (nxt_link.phase)
          fl_pkg::PH_DUMMY:
          begin
            if (k == 1)
            begin
              nxt_link.dummy = nxt_link.dummy - 5'h01;
              if (nxt_link.dummy == 5'h00)
                nxt_link = begin_read(nxt_link);
            end
          end
          fl_pkg::PH_INST, fl_pkg::PH_ADDR, fl_pkg::PH_WDATA, fl_pkg::PH_PARAM:
          begin
            case (nxt_link.phase)
              fl_pkg::PH_ADDR: w = nxt_link.cmd.addr_w;
              fl_pkg::PH_WDATA: w = nxt_link.cmd.data_w;
              default: w = nxt_link.four_line ? 3'h4 : 3'h1;
            endcase
            nxt_link.sh = (nxt_link.sh << w) | 32'(lane_in(w, smp));
            nxt_link.bits = nxt_link.bits - 6'(w);
            if (nxt_link.bits == 6'h00)
              nxt_link = finish(nxt_link);
          end
          default: ;
        endcase
      end
      if (k == 0)
        nxt_link.fall_pend = 1'b0;
    end
    nxt_link.fall_pend = nxt_link.cmd.dtr && (nxt_link.phase == fl_pkg::PH_ADDR);
    // unit 0 leaves on this rising edge (double-edge only), unit 1 on the next fall
    for (int k = 0; k < 2; k++)
    begin
      if (nxt_link.phase == fl_pkg::PH_RDATA && (k == 1 || (nxt_link.cmd.dtr && was_rd)))
      begin
        w = nxt_link.cmd.data_w;
        unit = lane_out(w, 4'(nxt_link.rd_byte >> (4'h8 - {1'b0, w})));
        nxt_link.rd_byte = nxt_link.rd_byte << w;
        nxt_link.rd_bits = nxt_link.rd_bits - {1'b0, w};
        if (k == 0)
          nxt_link.rise_x = unit ^ fall_x_ff;
        else
          nxt_link.out_fall = unit;
        if (nxt_link.rd_bits == 4'h0)
        begin
          if (nxt_link.cmd.kind == fl_pkg::K_READ)
            nxt_link.addr = wrap_inc(nxt_link.addr, 3 + int'(nxt_link.wrap_len),
              nxt_link.wrap_en);
          nxt_link.rd_byte = fetch(nxt_link);
          nxt_link.rd_bits = 4'h8;
        end
      end
    end
  end

  always_ff @(posedge link_clk or posedge sys_ff.link_rst)
  begin
    if (sys_ff.link_rst)
      link_ff <= LINK_INIT;
    else
      link_ff <= nxt_link;
  end

  // marks a frame in progress; cleared the moment chip enable rises
  always_ff @(posedge link_clk or posedge frame_clr)
  begin
    if (frame_clr)
      live_ff <= 1'b0;
    else
      live_ff <= 1'b1;
  end

  // falling-edge half: sample for double-edge input, xor launch for output
  always_ff @(negedge link_clk or posedge sys_ff.link_rst)
  begin
    if (sys_ff.link_rst)
    begin
      fall_in_ff <= 4'h0;
      fall_x_ff <= 4'h0;
    end
    else
    begin
      fall_in_ff <= pin_in;
      fall_x_ff <= link_ff.out_fall ^ link_ff.rise_x;
    end
  end

  // xor pair gives a double-edge output with no clock in the data path
  assign lines_out = fl_pkg::lines_t'(link_ff.rise_x ^ fall_x_ff);
  assign lines_oe_n = fl_pkg::lines_t'(~(link_ff.drive & {4{live_ff}}));

  // system side: stretched reset into the link domain, mode flags synchronised back
  always_comb
  begin
    nxt_sys = sys_ff;
    nxt_sys.sync1.four_line_command_mode = link_ff.four_line;
    nxt_sys.sync1.addr4_mode = link_ff.addr4;
    nxt_sys.sync1.wrap_enable = link_ff.wrap_en;
    nxt_sys.sync1.write_enabled = link_ff.wel;
    nxt_sys.sync2 = sys_ff.sync1;
    if (rst)
    begin
      nxt_sys.hold = `LINK_RST_HOLD;
      nxt_sys.link_rst = 1'b1;
      nxt_sys.sync1 = '0;
      nxt_sys.sync2 = '0;
    end
    else if (sys_ff.hold != 4'h0)
      nxt_sys.hold = sys_ff.hold - 4'h1;
    else
      nxt_sys.link_rst = 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    sys_ff <= nxt_sys;
  end

  assign mode_status = sys_ff.sync2;
endmodule

/* File: tb/serial_flash_host_interface_properties.sv */
`timescale 1ns/1ps
// pin-level checks; link phase is counted from the fall of chip enable
module flash_if_checker (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire fl_pkg::lines_t lines_in,
  input wire fl_pkg::lines_t lines_out,
  input wire fl_pkg::lines_t lines_oe_n,
  input wire fl_pkg::mode_status_t mode_status
);
  logic [3:0] edge_cnt_ff;
  // rising link edges in this frame; cleared at once by chip enable, saturates
  always_ff @(posedge link_clk or posedge cs_n)
  begin
    if (cs_n)
      edge_cnt_ff <= 4'h0;
    else if (edge_cnt_ff != 4'hf)
      edge_cnt_ff <= edge_cnt_ff + 4'h1;
  end

  oe_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    cs_n |-> lines_oe_n == 4'hf) else $error("pin driven while deselected");
  rst_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> (mode_status == 4'h0) [*8]) else $error("mode kept over reset");
  rst_oe_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(rst) |-> (lines_oe_n == 4'hf) [*8]) else $error("pin driven after reset");
  lane_group_a: assert property (@(posedge sys_clk) disable iff (rst)
    lines_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0}) else $error("illegal lane group");
  quad_lanes_a: assert property (@(posedge sys_clk) disable iff (rst)
    mode_status.four_line_command_mode && lines_oe_n != 4'hf |-> lines_oe_n == 4'h0)
    else $error("four-line mode not on all lanes");
  // status may only move inside a frame; the sync delay is covered by six idle samples
  mode_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    cs_n [*6] |-> $stable(mode_status)) else $error("mode moved between frames");
  opcode_quiet_a: assert property (@(posedge link_clk) disable iff (rst)
    !cs_n && edge_cnt_ff < 4'h8 && !mode_status.four_line_command_mode
    |-> lines_oe_n == 4'hf) else $error("driven during single-line opcode");
  qpi_opcode_a: assert property (@(posedge link_clk) disable iff (rst)
    !cs_n && edge_cnt_ff < 4'h2 |-> lines_oe_n == 4'hf) else $error("driven during opcode");
endmodule

bind serial_flash_host_interface flash_if_checker chk_u (.sys_clk(sys_clk), .rst(rst),
  .link_clk(link_clk), .cs_n(cs_n), .lines_in(lines_in), .lines_out(lines_out),
  .lines_oe_n(lines_oe_n), .mode_status(mode_status));

/* File: tb/flash_host_model.sv */
`timescale 1ns/1ps
// host controller: clock runs only inside frames, idle level from cpol (mode 0 or 3)
module flash_host_model (
  output logic link_clk,
  output logic cs_n,
  output fl_pkg::lines_t lines_in,
  input wire fl_pkg::lines_t lines_out,
  input wire fl_pkg::lines_t lines_oe_n
);
  logic cpol;
  logic [3:0] host_val;
  logic [3:0] dev_v;
  logic [3:0] en_n;
  logic [3:0] pin_v;
  // pin level: device wins where enabled, else the host value (toggles when released)
  assign dev_v = lines_out;
  assign en_n = lines_oe_n;
  assign pin_v = (dev_v & ~en_n) | (host_val & en_n);
  assign lines_in = fl_pkg::lines_t'(pin_v);

  initial
  begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    cpol = 1'b0;
    host_val = 4'h0;
  end

  task automatic cs_lo();
    link_clk = cpol;
    #15;
    cs_n = 1'b0;
    #15;
  endtask

  task automatic cs_hi();
    link_clk = cpol;
    #15;
    cs_n = 1'b1;
    #60;
  endtask

  // one clock per unit: drive after the fall, sample just before the rise
  task automatic xfer(input int nb, input int ln, input logic [31:0] wd, input bit drv,
                      output logic [31:0] rd);
    int k;
    int j;
    rd = 32'h0;
    for (k = nb; k > 0; k -= ln)
    begin
      link_clk = 1'b0;
      #1;
      for (j = 0; j < 4; j++)
        host_val[j] = (drv && j < ln) ? wd[k - ln + j] : ~host_val[j];
      #14;
      rd = (ln == 1) ? {rd[30:0], pin_v[1]} :
           (rd << ln) | {28'h0, (ln == 4) ? pin_v : {2'b00, pin_v[1:0]}};
      link_clk = 1'b1;
      #15;
    end
  endtask
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
// self-checking bench; a byte map of the array predicts the array reads, erased reads and the status read are checked against fixed values
module tb_top;
  localparam int MEM_AW = 13;
  localparam int PAGE_AW = 8;
  localparam int MSK = (1 << MEM_AW) - 1;
  localparam int PG = (1 << PAGE_AW) - 1;
  localparam int LIMIT = 60000;
  logic sys_clk;
  logic rst;
  logic link_clk;
  logic cs_n;
  fl_pkg::lines_t lines_in;
  fl_pkg::lines_t lines_out;
  fl_pkg::lines_t lines_oe_n;
  fl_pkg::mode_status_t mode_status;
  int err_count;
  int total_checks;
  int cyc = 0;
  int seed;
  int pa0;
  int pa1;
  int i;
  bit q;
  bit a4;
  logic [31:0] rd;
  logic [15:0] wd0;
  logic [15:0] wd1;
  logic [7:0] mem [int];
  logic [7:0] ops [6] = '{8'h03, 8'h0b, 8'h3b, 8'h6b, 8'hbb, 8'heb};
  int al [6] = '{1, 1, 1, 1, 2, 4};
  int dm [6] = '{0, 8, 8, 8, 4, 6};
  int dl [6] = '{1, 1, 2, 4, 2, 4};

  serial_flash_host_interface #(.MEM_AW(MEM_AW), .PAGE_AW(PAGE_AW), .BIG_BLOCK(1'b0)) dut_u (
    .sys_clk(sys_clk), .rst(rst), .link_clk(link_clk), .cs_n(cs_n), .lines_in(lines_in),
    .lines_out(lines_out), .lines_oe_n(lines_oe_n), .mode_status(mode_status));
  flash_host_model host_u (.link_clk(link_clk), .cs_n(cs_n), .lines_in(lines_in),
    .lines_out(lines_out), .lines_oe_n(lines_oe_n));

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // hang guard well above the expected run length
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      err_count++;
      complete_run();
    end
  end

  function automatic logic [15:0] exp2(int a);
    logic [7:0] b0;
    logic [7:0] b1;
    b0 = mem.exists(a & MSK) ? mem[a & MSK] : 8'hff;
    b1 = mem.exists((a + 1) & MSK) ? mem[(a + 1) & MSK] : 8'hff;
    return {b0, b1};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send_op(input logic [7:0] op);
    host_u.xfer(8, q ? 4 : 1, {24'h0, op}, 1'b1, rd);
  endtask

  task automatic op_only(input logic [7:0] op);
    host_u.cs_lo();
    send_op(op);
    host_u.cs_hi();
  endtask

  task automatic op_addr(input logic [7:0] op, input int a, input int ln);
    host_u.cs_lo();
    send_op(op);
    // a lane count of zero marks a command with no address phase
    if (ln > 0)
      host_u.xfer(a4 ? 32 : 24, ln, a, 1'b1, rd);
  endtask

  // two data bytes land in rd[15:0]
  task automatic rd_cmd(input logic [7:0] op, input int a, input int ln, input int d, int dln);
    op_addr(op, a, ln);
    if (d > 0)
      host_u.xfer(d, 1, 32'h0, 1'b0, rd);
    host_u.xfer(16, dln, 32'h0, 1'b0, rd);
    host_u.cs_hi();
  endtask

  // second byte wraps inside the page
  task automatic prog(input int a, input logic [15:0] d);
    op_only(8'h06);
    op_addr(8'h02, a, 1);
    host_u.xfer(16, 1, {16'h0, d}, 1'b1, rd);
    host_u.cs_hi();
    mem[a & MSK] = d[15:8];
    mem[((a & ~PG) | ((a + 1) & PG)) & MSK] = d[7:0];
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    seed = 32'h5c76;
    err_count = 0;
    total_checks = 0;
    q = 1'b0;
    a4 = 1'b0;
    rst = 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (12) @(posedge sys_clk);
    chk(mode_status, 4'h0);
    chk(lines_oe_n, 4'hf);
    pa0 = (($random(seed) & 32'h0f) << PAGE_AW) | 32'hff;
    pa1 = 32'h1000 | ($random(seed) & 32'hefe);
    wd0 = 16'($random(seed));
    wd1 = 16'($random(seed));
    rd_cmd(8'h03, pa1, 1, 0, 1);
    chk(rd[15:0], 16'hffff);
    $display("reset and erased test done");
    op_only(8'h06);
    rd_cmd(8'h05, 0, 0, 0, 1);
    chk(rd[15:8], 8'h02);
    chk(mode_status.write_enabled, 1'b1);
    prog(pa0, wd0);
    prog(pa1, wd1);
    rd_cmd(8'h03, pa0 & ~PG, 1, 0, 1);
    chk(rd[15:0], exp2(pa0 & ~PG));
    for (i = 0; i < 6; i++)
    begin
      rd_cmd(ops[i], pa1, al[i], dm[i], dl[i]);
      chk(rd[15:0], exp2(pa1));
    end
    $display("program and read test done");
    op_only(8'h06);
    op_addr(8'h20, pa1, 1);
    host_u.cs_hi();
    for (i = 32'h1000; i < 32'h2000; i++)
      if (mem.exists(i))
        mem.delete(i);
    rd_cmd(8'h03, pa1, 1, 0, 1);
    chk(rd[15:0], exp2(pa1));
    rd_cmd(8'h03, pa0, 1, 0, 1);
    chk(rd[15:0], exp2(pa0));
    op_only(8'h06);
    op_addr(8'h02, pa1, 1);
    host_u.xfer(4, 1, 32'h0, 1'b1, rd);
    host_u.cs_hi();
    rd_cmd(8'h03, pa1, 1, 0, 1);
    chk(rd[15:0], exp2(pa1));
    $display("erase and abort test done");
    op_only(8'hb7);
    chk(mode_status.addr4_mode, 1'b1);
    a4 = 1'b1;
    rd_cmd(8'h03, pa0, 1, 0, 1);
    chk(rd[15:0], exp2(pa0));
    op_only(8'h29);
    a4 = 1'b0;
    chk(mode_status.addr4_mode, 1'b0);
    op_only(8'h35);
    chk(mode_status.four_line_command_mode, 1'b1);
    q = 1'b1;
    rd_cmd(8'heb, pa0, 4, 6, 4);
    chk(rd[15:0], exp2(pa0));
    op_only(8'hf5);
    q = 1'b0;
    chk(mode_status.four_line_command_mode, 1'b0);
    op_only(8'h35);
    q = 1'b1;
    op_only(8'h66);
    op_only(8'h99);
    q = 1'b0;
    chk(mode_status, 4'h0);
    $display("mode switch test done");
    host_u.cpol = 1'b1;
    rd_cmd(8'h03, pa0, 1, 0, 1);
    chk(rd[15:0], exp2(pa0));
    host_u.cpol = 1'b0;
    // 8-byte wrap: the byte after offset 7 of the burst comes from offset 0
    host_u.cs_lo();
    send_op(8'hc0);
    host_u.xfer(8, 1, 32'h10, 1'b1, rd);
    host_u.cs_hi();
    chk(mode_status.wrap_enable, 1'b1);
    rd_cmd(8'h03, pa0, 1, 0, 1);
    chk(rd[15:8], exp2(pa0) >> 8);
    chk(rd[7:0], exp2(pa0 & ~7) >> 8);
    op_only(8'h06);
    op_only(8'hc7);
    mem.delete();
    rd_cmd(8'h03, pa0, 1, 0, 1);
    chk(rd[15:0], 16'hffff);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    mem.delete();
    repeat (12) @(posedge sys_clk);
    chk(mode_status, 4'h0);
    rd_cmd(8'h03, pa0, 1, 0, 1);
    chk(rd[15:0], 16'hffff);
    $display("clock mode and reset test done");
    complete_run();
  end
endmodule
